// File: design/seq_pkg.sv
// Constants and types shared by the supply-state sequencer
package seq_pkg;

  // Clock period of the internal clock in ns
  localparam int unsigned CLK_PERIOD_NS   = 20;
  // Start-up dwell time in ns (preset, parameterised at top)
  localparam int unsigned STARTUP_TIME_NS = 1000000;
  // Start-up dwell in cycles, rounded down, at least one
  localparam int unsigned STARTUP_CYCLES  = (STARTUP_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                            STARTUP_TIME_NS / CLK_PERIOD_NS;
  // Width of the start-up counter
  localparam int unsigned CNT_W           = 32;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_SLEEP   = 3'h1,
    ST_STARTUP = 3'h2,
    ST_ACTIVE  = 3'h4
  } state_type;

  // Shunt regulator target selection
  typedef enum logic [1:0] {
    REG_OFF     = 2'h0,
    REG_STARTUP = 2'h1,
    REG_RUN     = 2'h2
  } reg_sel_type;

  // Conversion mode handed to the mode controller
  localparam logic [2:0] MODE_STANDBY = 3'h0;

  // Value after reset of the counter
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0;

endpackage : seq_pkg

// File: design/input_sync.sv
// Two-flop synchroniser for the comparator levels
`timescale 1ns/10ps
module input_sync (
  input  wire logic clk_i,    // Internal clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  input  wire logic async_i,  // Asynchronous level
  output logic      sync_o    // Synchronised level
);
  logic meta_q;  // First stage, read only by second
  logic sync_q;  // Second stage

  // Two flip-flops in series
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule : input_sync

// File: design/supply_state_sequencer.sv
// Supply-state sequencer: Sleep, Start-up and Active
// How it works
// - Sleep powers down, holds switch drive off
// - Shunt regulator off in Sleep, on otherwise
// - Wake comparator moves Sleep to Start-up
// - Start-up enables blocks, conversion in Standby
// - Start-up selects high level, Active low
// - Start-up lasts preset time, then Active
// - Undervoltage in Active stops switching, Sleep
// - Undervoltage anywhere returns Sleep, rewake only
`timescale 1ns/10ps
module supply_state_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned STARTUP_COUNT = seq_pkg::STARTUP_CYCLES  // Start-up dwell cycles
) (
  input  wire logic               clk_i,            // Internal clock, 50 MHz
  input  wire logic               rst_n_i,          // Synchronous reset, active low
  input  wire logic               wake_above_i,     // VDD above wake_threshold
  input  wire logic               undervoltage_i,   // VDD below undervoltage_threshold
  input  wire logic               switch_req_i,     // Drive request from mode controller
  output logic                    switch_drive_o,   // switch_drive_output to primary_switch
  output seq_pkg::reg_sel_type    reg_sel_o,        // Shunt regulator target
  output logic                    blocks_en_o,      // Non-essential circuits powered
  output logic                    conv_en_o,        // Conversion enabled
  output logic                    mode_init_o,      // Pulse: load initial mode
  output logic [2:0]              mode_init_val_o,  // Initial conversion mode
  output logic                    high_demand_o,    // wake_supply_current drawn
  output seq_pkg::state_type      state_o           // Current state
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    state_type        st;     // Sequencer state
    logic [CNT_W-1:0] cnt;    // Start-up timer
    logic             init;   // Mode load pulse
    logic             drive;  // Registered switch drive
  } seq_state_type;

  seq_state_type s_q;  // Registered state
  seq_state_type s_d;  // Next state
  logic wake_s;        // Synchronised wake level
  logic uv_s;          // Synchronised undervoltage level

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers
  input_sync u_wake_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (wake_above_i),
    .sync_o  (wake_s)
  );

  input_sync u_uv_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (undervoltage_i),
    .sync_o  (uv_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    // Hold by default; the mode load pulse clears itself
    s_d      = s_q;
    s_d.init = 1'h0;
    unique case (s_q.st)
      ST_SLEEP: begin
        s_d.cnt = CNT_RESET;
        if (wake_s && !uv_s) begin
          s_d.st   = ST_STARTUP;
          s_d.init = 1'h1;
        end
      end
      ST_STARTUP: begin
        if (uv_s) begin
          s_d.st  = ST_SLEEP;
          s_d.cnt = CNT_RESET;
        end else if (s_q.cnt >= CNT_W'(STARTUP_COUNT - 1)) begin
          s_d.st = ST_ACTIVE;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_ACTIVE: begin
        if (uv_s) begin
          s_d.st  = ST_SLEEP;
          s_d.cnt = CNT_RESET;
        end
      end
      default: begin
        s_d.st  = ST_SLEEP;  // Illegal code recovers to Sleep
        s_d.cnt = CNT_RESET;
      end
    endcase
    // Drive only in conversion states and never on undervoltage
    s_d.drive = (s_d.st != ST_SLEEP) && switch_req_i && !uv_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_q.st    <= ST_SLEEP;
      s_q.cnt   <= CNT_RESET;
      s_q.init  <= 1'h0;
      s_q.drive <= 1'h0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign switch_drive_o  = s_q.drive;
  assign blocks_en_o     = (s_q.st != ST_SLEEP);
  assign conv_en_o       = (s_q.st != ST_SLEEP);
  assign high_demand_o   = (s_q.st != ST_SLEEP);
  assign mode_init_o     = s_q.init;
  assign mode_init_val_o = MODE_STANDBY;
  assign state_o         = s_q.st;
  // Regulator target per state
  always_comb begin
    unique case (s_q.st)
      ST_STARTUP: reg_sel_o = REG_STARTUP;
      ST_ACTIVE:  reg_sel_o = REG_RUN;
      default:    reg_sel_o = REG_OFF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_wake_seen;
    (s_q.st == ST_SLEEP) && wake_s && !uv_s;
  endsequence

  a_sleep_drive_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SLEEP) |-> !switch_drive_o && !blocks_en_o)
    else $error("Drive active in Sleep");
  a_reg_off_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SLEEP) == (reg_sel_o == REG_OFF))
    else $error("Regulator state mismatch");
  a_wake_to_startup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_seen |=> (s_q.st == ST_STARTUP))
    else $error("Wake did not start up");
  a_startup_mode_init: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_seen |=> mode_init_o && (mode_init_val_o == MODE_STANDBY) && conv_en_o)
    else $error("Start-up mode not loaded");
  a_reg_level_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_ACTIVE) |-> (reg_sel_o == REG_RUN))
    else $error("Run level not selected");
  a_startup_timeout: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_STARTUP) && !uv_s && (s_q.cnt == CNT_W'(STARTUP_COUNT - 1))
      |=> (s_q.st == ST_ACTIVE))
    else $error("Start-up did not end");
  a_active_uv_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_ACTIVE) && uv_s |=> (s_q.st == ST_SLEEP) && !switch_drive_o)
    else $error("Undervoltage ignored in Active");
  a_startup_uv_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_STARTUP) && uv_s |=> (s_q.st == ST_SLEEP) && !high_demand_o)
    else $error("Undervoltage ignored in Start-up");
  a_cnt_clear_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SLEEP) |=> (s_q.cnt == CNT_RESET))
    else $error("Counter not cleared in Sleep");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on pulses, gating and demand

  // Start-up just entered with the mode load pulse up
  sequence s_entry_pulse;
    (s_q.st == ST_STARTUP) && mode_init_o;
  endsequence

  // Undervoltage seen while converting
  sequence s_uv_converting;
    (s_q.st != ST_SLEEP) && uv_s;
  endsequence

  // Start-up timer expiring into Active
  sequence s_startup_done;
    (s_q.st == ST_STARTUP) ##1 (s_q.st == ST_ACTIVE);
  endsequence

  // Sleep with the load and the switch quiet
  sequence s_sleep_quiet;
    (s_q.st == ST_SLEEP) && !switch_drive_o && !high_demand_o && !conv_en_o;
  endsequence

  // Mode load lasts exactly one cycle
  a_init_one_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_wake_seen |=> s_entry_pulse ##1 !mode_init_o)
    else $error("Mode load pulse not one cycle");
  // Mode load only on the entry from Sleep
  a_init_only_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_init_o |-> (s_q.st == ST_STARTUP) && ($past(s_q.st) == ST_SLEEP))
    else $error("Mode load outside entry");
  // Start-up holds the high regulation level with blocks on
  a_startup_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_STARTUP) |-> (reg_sel_o == REG_STARTUP) && blocks_en_o && conv_en_o)
    else $error("Start-up level not selected");
  // Active only after the full dwell, conversion unbroken
  a_active_no_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_startup_done |-> conv_en_o && ($past(s_q.cnt) == CNT_W'(STARTUP_COUNT - 1)))
    else $error("Active entered early or conversion broken");
  // Undervoltage in Start-up or Active lands in a quiet Sleep
  a_uv_quiet_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_uv_converting |=> s_sleep_quiet)
    else $error("Undervoltage left load on");
  // Undervoltage keeps Sleep whatever wake says
  a_uv_holds_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SLEEP) && uv_s |=> (s_q.st == ST_SLEEP))
    else $error("Woke under undervoltage");
  // Sleep is left only towards Start-up
  a_sleep_exit_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_SLEEP) ##1 (s_q.st != ST_SLEEP) |-> (s_q.st == ST_STARTUP))
    else $error("Sleep left to wrong state");
  // Drive follows a request and never an undervoltage
  a_drive_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    switch_drive_o |-> $past(switch_req_i) && !$past(uv_s))
    else $error("Drive without request");
  // Start-up timer stays below its end count
  a_cnt_in_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_q.st == ST_STARTUP) |-> (s_q.cnt < CNT_W'(STARTUP_COUNT)))
    else $error("Start-up timer overran");

endmodule : supply_state_sequencer

// File: tb/supply_partner.sv
// Model of the supply comparators and the conversion mode controller
`timescale 1ns/10ps
module supply_partner #(
  parameter logic [15:0] WAKE_MV = 16'h0BB8,  // Wake level in mV
  parameter logic [15:0] UV_MV   = 16'h07D0   // Undervoltage level in mV
) (
  input  wire logic        clk_i,           // Internal clock
  input  wire logic [15:0] vdd_mv_i,        // Supply level from bench
  input  wire logic        conv_en_i,       // Conversion enabled
  output logic             wake_above_o,    // Supply above wake level
  output logic             undervoltage_o,  // Supply below undervoltage level
  output logic             switch_req_o     // Drive request
);
  logic req_q = 1'h0;  // Toggling request, held up when not converting
  ///////////////////////////////////////////////////////////////////////////
  // Comparators are plain levels with hysteresis between the two
  assign wake_above_o   = (vdd_mv_i > WAKE_MV);
  assign undervoltage_o = (vdd_mv_i < UV_MV);
  assign switch_req_o   = req_q;
  // Mode controller asks for on/off cycles while converting and leaves
  // its request up otherwise, which the sequencer must ignore
  always_ff @(posedge clk_i) begin
    req_q <= conv_en_i ? ~req_q : 1'h1;
  end
endmodule : supply_partner

// File: tb/tb_top.sv
// Self-checking bench of the supply-state sequencer
`timescale 1ns/10ps
module tb_top;
  import seq_pkg::*;
  localparam int unsigned SC = 8;  // Shortened dwell
  logic clk, rst_n, wake, uv, req, drv, blk, conv, mi, hd;
  logic [2:0]  miv;  // Initial mode
  logic [15:0] vdd;  // Supply level in mV
  reg_sel_type rs;   // Regulator target
  state_type   st;   // State
  int failures, cmp_count;
  supply_partner i_part (.clk_i(clk), .vdd_mv_i(vdd), .conv_en_i(conv), .wake_above_o(wake),
    .undervoltage_o(uv), .switch_req_o(req));
  supply_state_sequencer #(.STARTUP_COUNT(SC)) i_dut (.clk_i(clk), .rst_n_i(rst_n),
    .wake_above_i(wake), .undervoltage_i(uv), .switch_req_i(req), .switch_drive_o(drv),
    .reg_sel_o(rs), .blocks_en_o(blk), .conv_en_o(conv), .mode_init_o(mi),
    .mode_init_val_o(miv), .high_demand_o(hd), .state_o(st));
  ///////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      failures++;
    end
  endtask : chk
  task automatic setv(input logic [15:0] v);
    @(posedge clk);
    vdd <= v;
    #1;
  endtask : setv
  task automatic wait_st(input state_type s);
    int n = 0;
    while (st !== s && n < 40) begin
      cyc();
      n++;
    end
    chk("state", s, st);
  endtask : wait_st
  // Counts Start-up dwell and watches the drive in Active
  task automatic dwell(input int spent);
    int   n    = spent;
    logic seen = 1'h0;
    while (st === ST_STARTUP && n < 40) begin
      cyc();
      n++;
    end
    chk("dwell", 4'h1, {3'h0, (n == SC)});
    chk("active state", ST_ACTIVE, st);
    chk("reg run", REG_RUN, rs);
    chk("conv on", 4'h1, {3'h0, conv & blk & hd});
    repeat (6) begin
      cyc();
      seen = seen | drv;
    end
    chk("drive active", 4'h1, {3'h0, seen});
  endtask : dwell
  // Power-on reset: Sleep with everything off
  task automatic t_power_on();
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk("sleep state", ST_SLEEP, st);
    chk("sleep drive", 4'h0, {3'h0, drv | blk | hd});
    chk("sleep reg", REG_OFF, rs);
  endtask : t_power_on
  // Wake into Start-up with the Standby load pulse
  task automatic t_wake();
    setv(16'h0CE4);
    wait_st(ST_STARTUP);
    chk("mode init", 4'h1, {3'h0, mi});
    chk("mode val", MODE_STANDBY, miv);
    chk("blocks", 4'h1, {3'h0, blk & conv & hd});
    chk("reg start", REG_STARTUP, rs);
    cyc();
    chk("init pulse", 4'h0, {3'h0, mi});
  endtask : t_wake
  // Dwell into Active, then undervoltage back to Sleep
  task automatic t_active_uv();
    dwell(1);
    setv(16'h0640);
    wait_st(ST_SLEEP);
    chk("uv drive", 4'h0, {3'h0, drv | blk | hd});
    chk("uv reg", REG_OFF, rs);
  endtask : t_active_uv
  // Undervoltage inside Start-up returns to Sleep, never Active
  task automatic t_startup_uv();
    int n = 0;
    setv(16'h0CE4);
    wait_st(ST_STARTUP);
    setv(16'h0640);
    while (st === ST_STARTUP && n < 40) begin
      cyc();
      n++;
    end
    chk("startup uv", ST_SLEEP, st);
    chk("uv demand", 4'h0, {3'h0, hd | drv});
  endtask : t_startup_uv
  // Between thresholds: no rewake, request ignored
  task automatic t_no_rewake();
    logic woke  = 1'h0;
    logic drove = 1'h0;
    setv(16'h0A28);
    repeat (10) begin
      cyc();
      woke  = woke | (st !== ST_SLEEP);
      drove = drove | drv;
    end
    chk("no rewake", 4'h0, {3'h0, woke});
    chk("sleep gated", 4'h0, {3'h0, drove});
  endtask : t_no_rewake
  // Normal wake again with a cleared timer
  task automatic t_rewake();
    setv(16'h0CE4);
    wait_st(ST_STARTUP);
    dwell(0);
  endtask : t_rewake
  // Reset in Active, then a fresh start
  task automatic t_mid_reset();
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    chk("reset state", ST_SLEEP, st);
    chk("reset outs", 4'h0, {3'h0, drv | blk | hd | mi});
    chk("reset reg", REG_OFF, rs);
    @(posedge clk);
    rst_n <= 1'h1;
    #1;
    chk("release state", ST_SLEEP, st);
    wait_st(ST_STARTUP);
    dwell(0);
  endtask : t_mid_reset
  task automatic results();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  ///////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and scenarios
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #20000;  // About ten times the expected run
    failures++;
    results();
  end
  initial begin
    rst_n = 1'h0;
    vdd   = 16'h0640;
    t_power_on();
    t_wake();
    t_active_uv();
    t_startup_uv();
    t_no_rewake();
    t_rewake();
    t_mid_reset();
    results();
  end
endmodule : tb_top
